// [hw/bosc_params.svh]
`ifndef BOSC_PARAMS_SVH
`define BOSC_PARAMS_SVH

// register offsets
`define BOSC_ON_CFG_ADDR 16'h4058
`define BOSC_SLEEP_CFG_ADDR 16'h4059

// field positions, shared by both registers
`define BOSC_SLOT_MSB 15
`define BOSC_SLOT_LSB 13
`define BOSC_MODE_MSB 9
`define BOSC_MODE_LSB 8
`define BOSC_VCODE_MSB 6
`define BOSC_VCODE_LSB 0
`define BOSC_VCODE_HI_LSB 2

// reset values
`define BOSC_ON_SLOT_RST 3'h0
`define BOSC_ON_MODE_RST 2'h1
`define BOSC_ON_VCODE_RST 7'h00
`define BOSC_SLEEP_SLOT_RST 3'h0
`define BOSC_SLEEP_MODE_RST 2'h3
`define BOSC_SLEEP_VCODE_RST 7'h00
`define BOSC_RATE_RST 2'h0

// voltage code saturation points and limit
`define BOSC_VCODE_MIN_SAT 7'h08
`define BOSC_VCODE_MAX_SAT 7'h68
`define BOSC_VSTEP_MAX 7'h60
`define BOSC_VCODE_4MHZ_LIMIT 7'h48

// slot codes
`define BOSC_SLOT_NONE 3'h0
`define BOSC_SLOT_HW1 3'h6
`define BOSC_SLOT_HW2 3'h7
`define BOSC_SLOT_LAST 3'h5

// switching rate codes
`define BOSC_RATE_2MHZ 2'h1
`define BOSC_RATE_4MHZ 2'h2

`endif

// [hw/bosc_pkg.sv]
`default_nettype none
package bosc_pkg;

    typedef enum logic [1:0] {
        BOSC_MODE_FORCED_CCM = 2'h0,
        BOSC_MODE_AUTO = 2'h1,
        BOSC_MODE_LINEAR = 2'h2,
        BOSC_MODE_HYSTERETIC = 2'h3
    } bosc_mode_e;

    typedef enum logic [2:0] {
        BOSC_ST_OFF = 3'h1,
        BOSC_ST_ON = 3'h2,
        BOSC_ST_SLEEP = 3'h4
    } bosc_state_e;

endpackage
`default_nettype wire

// [hw/bosc_regs.sv]
// Operation
// - on slot: 000 off, 1-5 enable slot
// - on slot 110/111 follows hardware enable
// - on mode four encodings, resets to auto
// - seven-bit on code, 12.5mV steps, zero reset
// - codes saturate below 09h, above 67h
// - config load sets top five on bits
// - sleep 000/110/111: transition in slot 5/3/1
// - sleep 001-101 disable in slots 5-1
// - hardware-enabled: 001-101 pick sleep entry slot
// - sleep mode same encoding, resets to hysteretic
// - seven-bit sleep code, same encoding, zero reset
// - switching rate 10 means 4MHz, 01 2MHz
`timescale 1ns/100ps
`default_nettype none
`include "bosc_params.svh"

module bosc_regs #(
    parameter int ADDR_W = 16
) (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic [ADDR_W-1:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [15:0] reg_rdata_out,
    input wire logic hw_enable1_in,
    input wire logic hw_enable2_in,
    input wire logic seq_slot_strobe_in,
    input wire logic seq_powerup_in,
    input wire logic [2:0] seq_timeslot_in,
    input wire logic cfg_load_in,
    input wire logic [4:0] cfg_on_vcode_hi_in,
    input wire logic [1:0] cfg_switching_rate_in,
    output logic buck1_enable_out,
    output logic buck1_sleep_out,
    output logic [1:0] buck1_conduction_mode_out,
    output logic [6:0] buck1_voltage_step_out,
    output logic buck1_rate_4mhz_out,
    output logic buck1_rate_valid_out,
    output logic buck1_vcode_over_limit_out
);

    // both offsets need fifteen address bits; a narrower bus would alias them
    generate
        if (ADDR_W < 15)
        begin : g_addr_check
            $error("bosc_regs: ADDR_W too small for register offsets");
        end
    endgenerate

    // register fields
    logic [2:0] on_slot_reg, on_slot_next;
    logic [1:0] on_mode_reg, on_mode_next;
    logic [6:0] on_vcode_reg, on_vcode_next;
    logic [2:0] sleep_slot_reg, sleep_slot_next;
    logic [1:0] sleep_mode_reg, sleep_mode_next;
    logic [6:0] sleep_vcode_reg, sleep_vcode_next;
    logic [1:0] rate_reg, rate_next;
    logic [15:0] rdata_reg, rdata_next;

    logic sel_on, sel_sleep;

    assign sel_on = (reg_addr_in == ADDR_W'(`BOSC_ON_CFG_ADDR));
    assign sel_sleep = (reg_addr_in == ADDR_W'(`BOSC_SLEEP_CFG_ADDR));

    always_comb
    begin
        on_slot_next = on_slot_reg;
        on_mode_next = on_mode_reg;
        on_vcode_next = on_vcode_reg;
        sleep_slot_next = sleep_slot_reg;
        sleep_mode_next = sleep_mode_reg;
        sleep_vcode_next = sleep_vcode_reg;
        rate_next = rate_reg;
        rdata_next = 16'h0000;
        if (reg_wr_in && sel_on)
        begin
            // only defined fields take write data
            on_slot_next = reg_wdata_in[`BOSC_SLOT_MSB:`BOSC_SLOT_LSB];
            on_mode_next = reg_wdata_in[`BOSC_MODE_MSB:`BOSC_MODE_LSB];
            on_vcode_next = reg_wdata_in[`BOSC_VCODE_MSB:`BOSC_VCODE_LSB];
        end
        if (reg_wr_in && sel_sleep)
        begin
            sleep_slot_next = reg_wdata_in[`BOSC_SLOT_MSB:`BOSC_SLOT_LSB];
            sleep_mode_next = reg_wdata_in[`BOSC_MODE_MSB:`BOSC_MODE_LSB];
            sleep_vcode_next = reg_wdata_in[`BOSC_VCODE_MSB:`BOSC_VCODE_LSB];
        end
        if (cfg_load_in)
        begin
            // load wins over a same-cycle bus write of the upper bits
            on_vcode_next[`BOSC_VCODE_MSB:`BOSC_VCODE_HI_LSB] = cfg_on_vcode_hi_in;
            rate_next = cfg_switching_rate_in;
        end
        if (reg_rd_in && sel_on)
        begin
            rdata_next[`BOSC_SLOT_MSB:`BOSC_SLOT_LSB] = on_slot_reg;
            rdata_next[`BOSC_MODE_MSB:`BOSC_MODE_LSB] = on_mode_reg;
            rdata_next[`BOSC_VCODE_MSB:`BOSC_VCODE_LSB] = on_vcode_reg;
        end
        else if (reg_rd_in && sel_sleep)
        begin
            rdata_next[`BOSC_SLOT_MSB:`BOSC_SLOT_LSB] = sleep_slot_reg;
            rdata_next[`BOSC_MODE_MSB:`BOSC_MODE_LSB] = sleep_mode_reg;
            rdata_next[`BOSC_VCODE_MSB:`BOSC_VCODE_LSB] = sleep_vcode_reg;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            on_slot_reg <= `BOSC_ON_SLOT_RST;
            on_mode_reg <= `BOSC_ON_MODE_RST;
            on_vcode_reg <= `BOSC_ON_VCODE_RST;
            sleep_slot_reg <= `BOSC_SLEEP_SLOT_RST;
            sleep_mode_reg <= `BOSC_SLEEP_MODE_RST;
            sleep_vcode_reg <= `BOSC_SLEEP_VCODE_RST;
            rate_reg <= `BOSC_RATE_RST;
            rdata_reg <= 16'h0000;
        end
        else
        begin
            on_slot_reg <= on_slot_next;
            on_mode_reg <= on_mode_next;
            on_vcode_reg <= on_vcode_next;
            sleep_slot_reg <= sleep_slot_next;
            sleep_mode_reg <= sleep_mode_next;
            sleep_vcode_reg <= sleep_vcode_next;
            rate_reg <= rate_next;
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata_out = rdata_reg;

    // hardware enable pins come from outside; two flops before use
    logic [1:0] hw_meta_reg, hw_meta_next;
    logic [1:0] hw_sync_reg, hw_sync_next;

    always_comb
    begin
        hw_meta_next = {hw_enable2_in, hw_enable1_in};
        hw_sync_next = hw_meta_reg;
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            hw_meta_reg <= 2'h0;
            hw_sync_reg <= 2'h0;
        end
        else
        begin
            hw_meta_reg <= hw_meta_next;
            hw_sync_reg <= hw_sync_next;
        end
    end

    // converter state
    bosc_pkg::bosc_state_e state_reg, state_next;
    logic hw_ctrl, hw_level, slot_hit_on, slot_hit_sleep, sleep_disables;
    logic [2:0] sleep_target_slot;

    assign hw_ctrl = (on_slot_reg == `BOSC_SLOT_HW1) || (on_slot_reg == `BOSC_SLOT_HW2);
    assign hw_level = (on_slot_reg == `BOSC_SLOT_HW1) ? hw_sync_reg[0] : hw_sync_reg[1];

    always_comb
    begin
        // slot in which the sleep code acts
        case (sleep_slot_reg)
            3'h0: sleep_target_slot = 3'h5;
            3'h1: sleep_target_slot = 3'h5;
            3'h2: sleep_target_slot = 3'h4;
            3'h3: sleep_target_slot = 3'h3;
            3'h4: sleep_target_slot = 3'h2;
            3'h5: sleep_target_slot = 3'h1;
            3'h6: sleep_target_slot = 3'h3;
            3'h7: sleep_target_slot = 3'h1;
            default: sleep_target_slot = 3'h5;
        endcase
    end

    // hardware-controlled converters never disable by slot; they sleep instead
    assign sleep_disables = (sleep_slot_reg != `BOSC_SLOT_NONE)
        && (sleep_slot_reg <= `BOSC_SLOT_LAST) && !hw_ctrl;
    assign slot_hit_on = seq_slot_strobe_in && seq_powerup_in
        && (on_slot_reg != `BOSC_SLOT_NONE) && (on_slot_reg == seq_timeslot_in);
    assign slot_hit_sleep = seq_slot_strobe_in && !seq_powerup_in
        && (seq_timeslot_in == sleep_target_slot);

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            bosc_pkg::BOSC_ST_OFF:
            begin
                if (hw_ctrl)
                begin
                    if (hw_level)
                    begin
                        state_next = bosc_pkg::BOSC_ST_ON;
                    end
                end
                else if (slot_hit_on)
                begin
                    state_next = bosc_pkg::BOSC_ST_ON;
                end
            end
            bosc_pkg::BOSC_ST_ON:
            begin
                if (hw_ctrl && !hw_level)
                begin
                    state_next = bosc_pkg::BOSC_ST_OFF;
                end
                else if (!hw_ctrl && on_slot_reg == `BOSC_SLOT_NONE)
                begin
                    state_next = bosc_pkg::BOSC_ST_OFF;
                end
                else if (slot_hit_sleep && sleep_disables)
                begin
                    state_next = bosc_pkg::BOSC_ST_OFF;
                end
                else if (slot_hit_sleep)
                begin
                    state_next = bosc_pkg::BOSC_ST_SLEEP;
                end
            end
            bosc_pkg::BOSC_ST_SLEEP:
            begin
                if (hw_ctrl && !hw_level)
                begin
                    state_next = bosc_pkg::BOSC_ST_OFF;
                end
                else if (!hw_ctrl && on_slot_reg == `BOSC_SLOT_NONE)
                begin
                    state_next = bosc_pkg::BOSC_ST_OFF;
                end
                else if (seq_slot_strobe_in && seq_powerup_in)
                begin
                    // any power-up slot returns to on settings
                    state_next = bosc_pkg::BOSC_ST_ON;
                end
            end
            default:
            begin
                state_next = bosc_pkg::BOSC_ST_OFF;
            end
        endcase
    end

    // outputs
    // mode and step follow the next state, so they move in the same cycle as enable
    // trade-off: one mux level more in front of the output flops
    logic [1:0] mode_next, mode_reg;
    logic [6:0] vcode_sel, step_sel, step_reg;
    logic over_sel, over_reg;

    assign vcode_sel = (state_next == bosc_pkg::BOSC_ST_SLEEP) ? sleep_vcode_reg : on_vcode_reg;
    assign mode_next = (state_next == bosc_pkg::BOSC_ST_SLEEP) ? sleep_mode_reg : on_mode_reg;

    bosc_vcode_decode u_decode (
        .code_in(vcode_sel),
        .step_out(step_sel),
        .over_4mhz_limit_out(over_sel)
    );

    always_ff @(posedge clk_sys_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            state_reg <= bosc_pkg::BOSC_ST_OFF;
            mode_reg <= `BOSC_ON_MODE_RST;
            step_reg <= 7'h00;
            over_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            mode_reg <= mode_next;
            step_reg <= step_sel;
            over_reg <= over_sel && (rate_next == `BOSC_RATE_4MHZ);
        end
    end

    assign buck1_enable_out = (state_reg != bosc_pkg::BOSC_ST_OFF);
    assign buck1_sleep_out = (state_reg == bosc_pkg::BOSC_ST_SLEEP);
    assign buck1_conduction_mode_out = mode_reg;
    assign buck1_voltage_step_out = step_reg;
    assign buck1_rate_4mhz_out = (rate_reg == `BOSC_RATE_4MHZ);
    assign buck1_rate_valid_out = (rate_reg == `BOSC_RATE_4MHZ)
        || (rate_reg == `BOSC_RATE_2MHZ);
    assign buck1_vcode_over_limit_out = over_reg;

endmodule
`default_nettype wire

// [hw/bosc_vcode_decode.sv]
`timescale 1ns/100ps
`default_nettype none
`include "bosc_params.svh"

module bosc_vcode_decode (
    input wire logic [6:0] code_in,
    output logic [6:0] step_out,
    output logic over_4mhz_limit_out
);

    always_comb
    begin
        // both ends saturate
        if (code_in <= `BOSC_VCODE_MIN_SAT)
        begin
            step_out = 7'h00;
        end
        else if (code_in >= `BOSC_VCODE_MAX_SAT)
        begin
            step_out = `BOSC_VSTEP_MAX;
        end
        else
        begin
            step_out = code_in - `BOSC_VCODE_MIN_SAT;
        end
    end

    // software owns the limit; flagged only
    assign over_4mhz_limit_out = (code_in > `BOSC_VCODE_4MHZ_LIMIT);

endmodule
`default_nettype wire

// [tb/bosc_regs_sva.sv]
`timescale 1ns/100ps
`default_nettype none
module bosc_regs_chk (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [15:0] reg_rdata_out,
    input wire logic hw_enable1_in,
    input wire logic hw_enable2_in,
    input wire logic seq_slot_strobe_in,
    input wire logic seq_powerup_in,
    input wire logic buck1_enable_out,
    input wire logic buck1_sleep_out,
    input wire logic [6:0] buck1_voltage_step_out,
    input wire logic buck1_rate_4mhz_out,
    input wire logic buck1_rate_valid_out,
    input wire logic buck1_vcode_over_limit_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rstn_in);
    a_rd_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 16'h0000)
        else $error("read data not zero");
    a_rd_pad: assert property ($past(reg_rd_in) |-> !reg_rdata_out[7] &&
        reg_rdata_out[12:10] == 3'h0) else $error("undefined bits not zero");
    // pins pass two sync flops and the state flop, so look three samples back
    a_en_cause: assert property ($rose(buck1_enable_out) |->
        $past(seq_slot_strobe_in && seq_powerup_in) || $past(hw_enable1_in, 3) ||
        $past(hw_enable2_in, 3)) else $error("enable rose without cause");
    a_off_cause: assert property ($fell(buck1_enable_out) |->
        $past(seq_slot_strobe_in) || $past(reg_wr_in, 2) || !$past(hw_enable1_in, 3) ||
        !$past(hw_enable2_in, 3)) else $error("enable fell without cause");
    a_sleep_cause: assert property ($rose(buck1_sleep_out) |->
        $past(seq_slot_strobe_in && !seq_powerup_in)) else $error("sleep without strobe");
    a_wake_up: assert property (buck1_sleep_out && seq_slot_strobe_in && seq_powerup_in
        |=> !buck1_sleep_out) else $error("no wake from sleep");
    a_step_max: assert property (buck1_voltage_step_out <= 7'h60)
        else $error("step above saturation");
    a_rate_valid: assert property (buck1_rate_valid_out && !buck1_rate_4mhz_out |->
        !buck1_vcode_over_limit_out) else $error("limit flagged at 2MHz");
    a_limit_rate: assert property (buck1_vcode_over_limit_out |->
        buck1_rate_4mhz_out || $past(buck1_rate_4mhz_out)) else $error("limit without 4MHz");
    c_sleep: cover property ($rose(buck1_sleep_out));
    c_limit: cover property ($rose(buck1_vcode_over_limit_out));
    c_pin_on: cover property ($rose(buck1_enable_out) && !$past(seq_slot_strobe_in));
endmodule
bind bosc_regs bosc_regs_chk i_chk (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .hw_enable1_in(hw_enable1_in), .hw_enable2_in(hw_enable2_in),
    .seq_slot_strobe_in(seq_slot_strobe_in), .seq_powerup_in(seq_powerup_in),
    .buck1_enable_out(buck1_enable_out), .buck1_sleep_out(buck1_sleep_out),
    .buck1_voltage_step_out(buck1_voltage_step_out),
    .buck1_rate_4mhz_out(buck1_rate_4mhz_out), .buck1_rate_valid_out(buck1_rate_valid_out),
    .buck1_vcode_over_limit_out(buck1_vcode_over_limit_out));
`default_nettype wire

// [tb/test_buck1_on_sleep_config.sv]
`timescale 1ns/100ps
`default_nettype none
module test_buck1_on_sleep_config;
    logic clk_sys_in = 1'b0;
    logic rstn_in = 1'b0;
    logic wr = 1'b0, rd = 1'b0, stb = 1'b0, pup = 1'b0, ld = 1'b0, h1 = 1'b0, h2 = 1'b0;
    logic rdp = 1'b0, en, slp, r4, rv, ovl;
    logic [15:0] addr = 16'h0000, wd = 16'h0000, v, rdata;
    logic [2:0] ts = 3'h0;
    logic [4:0] vhi = 5'h00;
    logic [1:0] rate = 2'h0, mode;
    logic [6:0] step;
    logic [15:0] expq[$];
    logic [6:0] codes[7] = '{7'h00, 7'h08, 7'h09, 7'h48, 7'h67, 7'h68, 7'h7F};
    logic [2:0] slots[3] = '{3'h0, 3'h6, 3'h7};
    logic [2:0] sts[3] = '{3'h5, 3'h3, 3'h1};
    logic [1:0] rates[3] = '{2'h2, 2'h1, 2'h0};
    logic [2:0] flags[3] = '{3'h7, 3'h2, 3'h0};
    int miscompares = 0, tests_run = 0, cyc = 0, seed = 73;
    bosc_regs i_dut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .reg_addr_in(addr),
        .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .hw_enable1_in(h1), .hw_enable2_in(h2), .seq_slot_strobe_in(stb),
        .seq_powerup_in(pup), .seq_timeslot_in(ts), .cfg_load_in(ld),
        .cfg_on_vcode_hi_in(vhi), .cfg_switching_rate_in(rate), .buck1_enable_out(en),
        .buck1_sleep_out(slp), .buck1_conduction_mode_out(mode),
        .buck1_voltage_step_out(step), .buck1_rate_4mhz_out(r4),
        .buck1_rate_valid_out(rv), .buck1_vcode_over_limit_out(ovl));
    always #25 clk_sys_in = ~clk_sys_in;
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic cmp(input logic [15:0] g, input logic [15:0] e);
        tests_run++;
        if (g !== e)
        begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // reads park the expected word in wd too; harmless since wr stays low
    task automatic bus(input logic w, input logic [15:0] a, input logic [15:0] d);
        if (!w)
            expq.push_back(d);
        addr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        @(posedge clk_sys_in);
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clk_sys_in);
    endtask
    task automatic seq(input logic p, input logic [2:0] t);
        pup <= p;
        ts <= t;
        stb <= 1'b1;
        @(posedge clk_sys_in);
        stb <= 1'b0;
    endtask
    // mask lets off-state checks skip mode and step, which are unspecified then
    task automatic st(input logic [10:0] e, input logic [10:0] m);
        @(negedge clk_sys_in);
        cmp({5'h00, {en, slp, mode, step} & m}, {5'h00, e & m});
        @(posedge clk_sys_in);
    endtask
    task automatic ldc(input logic [1:0] r);
        vhi <= 5'h12;
        rate <= r;
        ld <= 1'b1;
        @(posedge clk_sys_in);
        ld <= 1'b0;
        @(posedge clk_sys_in);
    endtask
    function automatic logic [6:0] stp(input logic [6:0] c);
        if (c <= 7'h08)
            return 7'h00;
        if (c >= 7'h68)
            return 7'h60;
        return c - 7'h08;
    endfunction
    always @(posedge clk_sys_in)
        rdp <= rd;
    always @(negedge clk_sys_in)
        if (rdp)
            cmp(rdata, expq.pop_front());
    always @(posedge clk_sys_in)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            miscompares++;
            test_done;
        end
    end
    initial
    begin
        repeat (8) @(posedge clk_sys_in);
        rstn_in <= 1'b1;
        @(posedge clk_sys_in);
        bus(1'b0, 16'h4058, 16'h0100);
        bus(1'b0, 16'h4059, 16'h0300);
        bus(1'b0, 16'h405A, 16'h0000);
        bus(1'b1, 16'h4058, 16'hFFFF);
        bus(1'b0, 16'h4058, 16'hE37F);
        for (int i = 0; i < 8; i++)
        begin
            v = 16'($random(seed));
            bus(1'b1, 16'h4058 + 16'(i % 2), v);
            bus(1'b0, 16'h4058 + 16'(i % 2), v & 16'hE37F);
        end
        bus(1'b1, 16'h4058, 16'h6209);
        seq(1'b1, 3'h2);
        st(11'h000, 11'h600);
        seq(1'b1, 3'h3);
        st({2'b10, 2'h2, 7'h01}, 11'h7FF);
        for (int k = 1; k < 6; k++)
        begin
            bus(1'b1, 16'h4059, {3'(k), 13'h0000});
            seq(1'b0, 3'(6 - k));
            st(11'h000, 11'h600);
            seq(1'b1, 3'h3);
            st(11'h400, 11'h600);
        end
        foreach (codes[j])
        begin
            bus(1'b1, 16'h4058, {3'h3, 3'h0, 2'(j), 1'b0, codes[j]});
            st({2'b10, 2'(j), stp(codes[j])}, 11'h7FF);
        end
        for (int k = 0; k < 3; k++)
        begin
            bus(1'b1, 16'h4059, {slots[k], 13'h0010});
            seq(1'b0, sts[k]);
            st({2'b11, 2'h0, 7'h08}, 11'h7FF);
            seq(1'b1, 3'h1);
            st({2'b10, 2'h2, 7'h60}, 11'h7FF);
        end
        for (int k = 0; k < 2; k++)
        begin
            bus(1'b1, 16'h4058, {3'(6 + k), 13'h0100});
            {h2, h1} <= 2'(1 << k);
            repeat (4) @(posedge clk_sys_in);
            st(11'h400, 11'h600);
            bus(1'b1, 16'h4059, 16'h4000);
            seq(1'b0, 3'h4);
            st(11'h600, 11'h600);
            {h2, h1} <= 2'h0;
            repeat (4) @(posedge clk_sys_in);
            st(11'h000, 11'h600);
        end
        bus(1'b1, 16'h4058, 16'h6203);
        seq(1'b1, 3'h3);
        for (int k = 0; k < 3; k++)
        begin
            ldc(rates[k]);
            @(negedge clk_sys_in);
            cmp({13'h0000, r4, rv, ovl}, {13'h0000, flags[k]});
            @(posedge clk_sys_in);
        end
        bus(1'b0, 16'h4058, 16'h624B);
        test_done;
    end
endmodule
`default_nettype wire
